// >>> shared/sci_pkg.sv
package sci_pkg;
	// Register addresses on the processor bus
	localparam logic [31:0] ADDR_FRAME_MODE = 32'hFFFFFE80;
	localparam logic [31:0] ADDR_BIT_RATE = 32'hFFFFFE82;
	localparam logic [31:0] ADDR_SERIAL_CTRL = 32'hFFFFFE84;
	localparam logic [31:0] ADDR_TX_HOLDING = 32'hFFFFFE86;
	localparam logic [31:0] ADDR_SERIAL_STATUS = 32'hFFFFFE88;
	localparam logic [31:0] ADDR_RX_HOLDING = 32'hFFFFFE8A;
	localparam logic [31:0] ADDR_PORT_PIN_DATA = 32'h04000136;
	localparam logic [31:0] ADDR_PORT_CONTROL = 32'h04000116;

	// Reset values
	localparam logic [7:0] RST_FRAME_MODE = 8'h00;
	localparam logic [7:0] RST_BIT_RATE = 8'hFF;
	localparam logic [7:0] RST_SERIAL_CTRL = 8'h00;
	localparam logic [7:0] RST_TX_HOLDING = 8'hFF;
	localparam logic [7:0] RST_SERIAL_STATUS = 8'h84;
	localparam logic [7:0] RST_RX_HOLDING = 8'h00;
	localparam logic [7:0] RST_PORT_PIN_DATA = 8'h00;
	localparam logic [15:0] RST_PORT_CONTROL = 16'hA888;

	// frame_mode fields
	localparam int FM_SYNC = 7;
	localparam int FM_CHR7 = 6;
	localparam int FM_PAR_EN = 5;
	localparam int FM_ODD = 4;
	localparam int FM_STOP2 = 3;
	localparam int FM_MP = 2;
	localparam int FM_CKS_HI = 1;
	localparam int FM_CKS_LO = 0;

	// serial_control fields
	localparam int CR_TXIE = 7;
	localparam int CR_RXIE = 6;
	localparam int CR_TXEN = 5;
	localparam int CR_RXEN = 4;
	localparam int CR_TEIE = 2;
	localparam int CR_CKE1 = 1;
	localparam int CR_CLOCK_ENABLE_BIT0 = 0;

	// serial_status fields
	localparam int ST_TX_EMPTY_FLAG = 7;
	localparam int ST_RDRF = 6;
	localparam int ST_ORER = 5;
	localparam int ST_FER = 4;
	localparam int ST_PER = 3;
	localparam int ST_TEND = 2;
	localparam int ST_MPB = 1;
	localparam int ST_MPBT = 0;

	// Port pin fields
	localparam int PD_SCK = 5;
	localparam int PD_SER = 4;
	localparam int PC_SCK_HI = 11;
	localparam int PC_SCK_LO = 10;
	localparam int PC_SER_HI = 9;
	localparam int PC_SER_LO = 8;
	localparam logic [1:0] PIN_MODE_OUT = 2'h1;

	// Timing: 16 ticks per bit, centre sample after 8
	localparam logic [3:0] PH_MID = 4'h7;
	localparam logic [3:0] PH_LAST = 4'hF;
	localparam logic [2:0] SCK_HALF = 3'h7;
	localparam logic [2:0] LAST_BIT8 = 3'h7;
	localparam logic [2:0] LAST_BIT7 = 3'h6;
	localparam logic [7:0] MASK8 = 8'hFF;
	localparam logic [7:0] MASK7 = 8'h7F;

	// Prescaler terminal counts for clock select 0..3
	localparam logic [5:0] PRESC_1 = 6'h00;
	localparam logic [5:0] PRESC_4 = 6'h03;
	localparam logic [5:0] PRESC_16 = 6'h0F;
	localparam logic [5:0] PRESC_64 = 6'h3F;

	localparam int DATA_W = 8;
	localparam int BUS_W = 16;
	localparam int RX_FIFO_DEPTH = 16;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2, TX_SYNC} sci_tx_st_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_SYNC} sci_rx_st_t;
endpackage

// >>> src/sci_top.sv
`timescale 1ns/1ps

// Plain synchronous FIFO, one word in and out per cycle
module sci_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Word storage
	logic [AW-1:0] wr_ptr_ff; // Next slot to fill
	logic [AW-1:0] rd_ptr_ff; // Oldest word
	logic [AW:0] count_ff; // Words held
	logic push;
	logic pop;

	assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (count_ff != '0);
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem[rd_ptr_ff];

	// Storage array, no reset needed
	always_ff @(posedge clk_i) begin
		if (clk_en_i && push) begin
			mem[wr_ptr_ff] <= in_data_i;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else if (clk_en_i) begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module sci_top (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic [31:0] bus_addr_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [sci_pkg::BUS_W-1:0] bus_wdata_i,
	output logic [sci_pkg::BUS_W-1:0] bus_rdata_o,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_oe_o,
	input wire logic serial_clock_pin_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_oe_o,
	output logic irq_tx_empty_o,
	output logic irq_tx_end_o,
	output logic irq_rx_full_o,
	output logic irq_rx_err_o
);
	import sci_pkg::*;

	// Software-visible registers
	logic [7:0] frame_mode_ff;
	logic [7:0] bit_rate_divisor_ff;
	logic [7:0] serial_control_ff;
	logic [7:0] tx_holding_ff;
	logic [7:0] rx_holding_ff;
	logic [7:0] port_pin_data_ff;
	logic [15:0] port_control_ff;
	logic tx_empty_flag_ff, rdrf_ff, orer_ff, fer_ff, per_ff, tend_ff, mpb_ff, mpbt_ff;

	// Decoded controls
	logic sync_mode, chr7, par_en, mp_en, tx_en, rx_en, ext_clk;
	logic [2:0] last_bit;
	logic [7:0] data_mask;
	assign sync_mode = frame_mode_ff[FM_SYNC];
	assign chr7 = frame_mode_ff[FM_CHR7] & ~sync_mode;
	assign par_en = frame_mode_ff[FM_PAR_EN] & ~frame_mode_ff[FM_MP] & ~sync_mode;
	assign mp_en = frame_mode_ff[FM_MP] & ~sync_mode;
	assign tx_en = serial_control_ff[CR_TXEN];
	assign rx_en = serial_control_ff[CR_RXEN];
	assign ext_clk = serial_control_ff[CR_CKE1];
	assign last_bit = chr7 ? LAST_BIT7 : LAST_BIT8;
	assign data_mask = chr7 ? MASK7 : MASK8;

	// Bus decode
	logic st_wr;
	assign st_wr = bus_wr_i & (bus_addr_i == ADDR_SERIAL_STATUS);

	// Pin synchronisers, first stage read only by the second
	logic rx_s1_ff, rx_s2_ff, sck_s1_ff, sck_s2_ff;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
			sck_s1_ff <= 1'b1;
			sck_s2_ff <= 1'b1;
		end else if (clk_en_i) begin
			rx_s1_ff <= serial_in_pin_i;
			rx_s2_ff <= rx_s1_ff;
			sck_s1_ff <= serial_clock_pin_i;
			sck_s2_ff <= sck_s1_ff;
		end
	end

	// Baud generator: prescaler then divisor, one tick per terminal count
	logic [5:0] presc_ff;
	logic [7:0] div_ff;
	logic [5:0] presc_max;
	logic presc_end, brg_tick;
	always_comb begin
		unique case (frame_mode_ff[FM_CKS_HI:FM_CKS_LO])
			2'h0: presc_max = PRESC_1;
			2'h1: presc_max = PRESC_4;
			2'h2: presc_max = PRESC_16;
			2'h3: presc_max = PRESC_64;
		endcase
	end
	assign presc_end = (presc_ff >= presc_max);
	assign brg_tick = presc_end & (div_ff >= bit_rate_divisor_ff);
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			presc_ff <= '0;
			div_ff <= '0;
		end else if (clk_en_i) begin
			presc_ff <= presc_end ? '0 : presc_ff + 1'b1;
			if (presc_end) begin
				div_ff <= brg_tick ? '0 : div_ff + 1'b1;
			end
		end
	end

	// Serial clock: internal divider or synchronised pin, with edge detect
	logic sck_int_ff, sck_prev_ff, sck_run, sck_src, sck_rise, sck_fall, tick;
	logic [2:0] sck_ph_ff;
	sci_tx_st_t tx_st_ff;
	sci_rx_st_t rx_st_ff;
	// Internal clock toggles in sync mode while in TX_SYNC or RX_SYNC, and in async mode while CR_CLOCK_ENABLE_BIT0 is set
	assign sck_run = ~ext_clk & (sync_mode ? (tx_st_ff == TX_SYNC || rx_st_ff == RX_SYNC)
		: serial_control_ff[CR_CLOCK_ENABLE_BIT0]);
	assign sck_src = ext_clk ? sck_s2_ff : sck_int_ff;
	assign sck_rise = sck_src & ~sck_prev_ff;
	assign sck_fall = ~sck_src & sck_prev_ff;
	assign tick = ext_clk ? sck_rise : brg_tick; // External clock is 16x bit rate in async
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sck_int_ff <= 1'b1;
			sck_ph_ff <= '0;
			sck_prev_ff <= 1'b1;
		end else if (clk_en_i) begin
			sck_prev_ff <= sck_src;
			if (!sck_run) begin
				sck_int_ff <= 1'b1; // Idle high
				sck_ph_ff <= '0;
			end else if (brg_tick) begin
				sck_ph_ff <= sck_ph_ff + 1'b1;
				if (sck_ph_ff == SCK_HALF) begin
					sck_int_ff <= ~sck_int_ff;
				end
			end
		end
	end

	// Transmitter
	logic [7:0] tx_shift_ff;
	logic [2:0] tx_bits_ff;
	logic [3:0] tx_ph_ff;
	logic tx_out_ff, tx_par_ff, tx_done_ff, tx_load, tx_bit_end;
	assign tx_load = (tx_st_ff == TX_IDLE) & tx_en & ~tx_empty_flag_ff;
	assign tx_bit_end = tick & (tx_ph_ff == PH_LAST);
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_st_ff <= TX_IDLE;
			tx_shift_ff <= '0;
			tx_bits_ff <= '0;
			tx_ph_ff <= '0;
			tx_out_ff <= 1'b1;
			tx_par_ff <= 1'b0;
			tx_done_ff <= 1'b0;
		end else if (clk_en_i) begin
			tx_done_ff <= 1'b0;
			if (tick) begin
				tx_ph_ff <= tx_ph_ff + 1'b1;
			end
			if (!tx_en) begin
				tx_st_ff <= TX_IDLE; // Disable aborts the frame
				tx_out_ff <= 1'b1;
			end else begin
				unique case (tx_st_ff)
					TX_IDLE: begin
						tx_out_ff <= 1'b1;
						if (tx_load) begin
							tx_shift_ff <= tx_holding_ff;
							tx_bits_ff <= '0;
							tx_ph_ff <= '0;
							tx_par_ff <= (^(tx_holding_ff & data_mask)) ^ frame_mode_ff[FM_ODD];
							if (sync_mode) begin
								tx_st_ff <= TX_SYNC;
								tx_out_ff <= tx_holding_ff[0];
							end else begin
								tx_st_ff <= TX_START;
								tx_out_ff <= 1'b0;
							end
						end
					end
					TX_START: if (tx_bit_end) begin
						tx_st_ff <= TX_DATA;
						tx_out_ff <= tx_shift_ff[0];
					end
					TX_DATA: if (tx_bit_end) begin
						if (tx_bits_ff == last_bit) begin
							if (par_en || mp_en) begin
								tx_st_ff <= TX_PAR;
								tx_out_ff <= mp_en ? mpbt_ff : tx_par_ff;
							end else begin
								tx_st_ff <= TX_STOP1;
								tx_out_ff <= 1'b1;
							end
						end else begin
							tx_shift_ff <= tx_shift_ff >> 1;
							tx_bits_ff <= tx_bits_ff + 1'b1;
							tx_out_ff <= tx_shift_ff[1];
						end
					end
					TX_PAR: if (tx_bit_end) begin
						tx_st_ff <= TX_STOP1;
						tx_out_ff <= 1'b1;
					end
					TX_STOP1: if (tx_bit_end) begin
						tx_st_ff <= frame_mode_ff[FM_STOP2] ? TX_STOP2 : TX_IDLE;
						tx_done_ff <= ~frame_mode_ff[FM_STOP2];
					end
					TX_STOP2: if (tx_bit_end) begin
						tx_st_ff <= TX_IDLE;
						tx_done_ff <= 1'b1;
					end
					TX_SYNC: begin
						// Data changes on falling edge, partner samples on rising; bit 0 waits for first rise
						if (sck_rise && tx_bits_ff == LAST_BIT8) begin
							tx_st_ff <= TX_IDLE;
							tx_done_ff <= 1'b1;
						end else if (sck_rise) begin
							tx_bits_ff <= tx_bits_ff + 1'b1;
						end else if (sck_fall && tx_bits_ff != '0) begin
							tx_shift_ff <= tx_shift_ff >> 1;
							tx_out_ff <= tx_shift_ff[1];
						end
					end
				endcase
			end
		end
	end

	// Receiver, independent of the transmitter
	logic [7:0] rx_shift_ff, rx_word_ff;
	logic [2:0] rx_bits_ff;
	logic [3:0] rx_ph_ff;
	logic rx_par_ff, rx_push_ff, rx_fer_ff, rx_per_ff, rx_bit_end;
	logic fifo_in_ready, fifo_out_valid;
	logic [7:0] fifo_out_data;
	assign rx_bit_end = tick & (rx_ph_ff == PH_LAST);
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_st_ff <= RX_IDLE;
			rx_shift_ff <= '0;
			rx_word_ff <= '0;
			rx_bits_ff <= '0;
			rx_ph_ff <= '0;
			rx_par_ff <= 1'b0;
			rx_push_ff <= 1'b0;
			rx_fer_ff <= 1'b0;
			rx_per_ff <= 1'b0;
		end else if (clk_en_i) begin
			rx_push_ff <= 1'b0;
			rx_fer_ff <= 1'b0;
			rx_per_ff <= 1'b0;
			if (tick) begin
				rx_ph_ff <= rx_ph_ff + 1'b1;
			end
			if (!rx_en) begin
				rx_st_ff <= RX_IDLE;
			end else begin
				unique case (rx_st_ff)
					RX_IDLE: begin
						rx_ph_ff <= '0;
						rx_bits_ff <= '0;
						if (sync_mode) begin
							rx_st_ff <= RX_SYNC;
						end else if (!rx_s2_ff) begin
							rx_st_ff <= RX_START;
						end
					end
					RX_START: if (tick && rx_ph_ff == PH_MID) begin
						// Recheck at start-bit centre to reject glitches
						rx_st_ff <= rx_s2_ff ? RX_IDLE : RX_DATA;
						rx_ph_ff <= '0;
					end
					RX_DATA: if (rx_bit_end) begin
						rx_shift_ff <= {rx_s2_ff, rx_shift_ff[7:1]};
						rx_bits_ff <= rx_bits_ff + 1'b1;
						if (rx_bits_ff == last_bit) begin
							rx_st_ff <= (par_en || mp_en) ? RX_PAR : RX_STOP;
						end
					end
					RX_PAR: if (rx_bit_end) begin
						rx_par_ff <= rx_s2_ff;
						rx_st_ff <= RX_STOP;
					end
					RX_STOP: if (rx_bit_end) begin
						// Only the first stop bit is checked
						rx_word_ff <= chr7 ? {1'b0, rx_shift_ff[7:1]} : rx_shift_ff;
						rx_push_ff <= 1'b1;
						rx_fer_ff <= ~rx_s2_ff;
						rx_per_ff <= par_en & ((^{rx_shift_ff[7:1], rx_shift_ff[0] & ~chr7}) ^ rx_par_ff
							^ frame_mode_ff[FM_ODD]);
						rx_st_ff <= RX_IDLE;
					end
					RX_SYNC: if (sck_rise) begin
						rx_shift_ff <= {rx_s2_ff, rx_shift_ff[7:1]};
						rx_bits_ff <= rx_bits_ff + 1'b1;
						if (rx_bits_ff == LAST_BIT8) begin
							rx_word_ff <= {rx_s2_ff, rx_shift_ff[7:1]};
							rx_push_ff <= 1'b1;
							rx_st_ff <= sync_mode ? RX_SYNC : RX_IDLE;
						end
					end
				endcase
			end
		end
	end

	// Receive FIFO between shifter and holding register; holding drains it
	logic rx_load;
	assign rx_load = fifo_out_valid & ~rdrf_ff;
	sci_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(RX_FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.in_valid_i(rx_push_ff),
		.in_ready_o(fifo_in_ready),
		.in_data_i(rx_word_ff),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(~rdrf_ff),
		.out_data_o(fifo_out_data)
	);

	// Status flags: hardware set wins over a software zero-write
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			{tx_empty_flag_ff, rdrf_ff, orer_ff, fer_ff, per_ff, tend_ff, mpb_ff, mpbt_ff} <= RST_SERIAL_STATUS;
		end else if (clk_en_i) begin
			if (tx_load) begin
				tx_empty_flag_ff <= 1'b1;
			end else if (st_wr && !bus_wdata_i[ST_TX_EMPTY_FLAG]) begin
				tx_empty_flag_ff <= 1'b0;
			end
			if (tx_done_ff && tx_empty_flag_ff) begin
				tend_ff <= 1'b1;
			end else if (tx_load || (st_wr && !bus_wdata_i[ST_TX_EMPTY_FLAG])) begin
				tend_ff <= 1'b0;
			end
			if (rx_load) begin
				rdrf_ff <= 1'b1;
			end else if (st_wr && !bus_wdata_i[ST_RDRF]) begin
				rdrf_ff <= 1'b0;
			end
			if (rx_push_ff && !fifo_in_ready) begin
				orer_ff <= 1'b1;
			end else if (st_wr && !bus_wdata_i[ST_ORER]) begin
				orer_ff <= 1'b0;
			end
			if (rx_fer_ff) begin
				fer_ff <= 1'b1;
			end else if (st_wr && !bus_wdata_i[ST_FER]) begin
				fer_ff <= 1'b0;
			end
			if (rx_per_ff) begin
				per_ff <= 1'b1;
			end else if (st_wr && !bus_wdata_i[ST_PER]) begin
				per_ff <= 1'b0;
			end
			if (rx_push_ff && mp_en) begin
				mpb_ff <= rx_par_ff;
			end
			if (st_wr) begin
				mpbt_ff <= bus_wdata_i[ST_MPBT];
			end
		end
	end

	// Holding register for received bytes
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_holding_ff <= RST_RX_HOLDING;
		end else if (clk_en_i && rx_load) begin
			rx_holding_ff <= fifo_out_data;
		end
	end

	// Register writes
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_mode_ff <= RST_FRAME_MODE;
			bit_rate_divisor_ff <= RST_BIT_RATE;
			serial_control_ff <= RST_SERIAL_CTRL;
			tx_holding_ff <= RST_TX_HOLDING;
			port_pin_data_ff <= RST_PORT_PIN_DATA;
			port_control_ff <= RST_PORT_CONTROL;
		end else if (clk_en_i && bus_wr_i) begin
			unique case (bus_addr_i)
				ADDR_FRAME_MODE: frame_mode_ff <= bus_wdata_i[7:0];
				ADDR_BIT_RATE: bit_rate_divisor_ff <= bus_wdata_i[7:0];
				ADDR_SERIAL_CTRL: serial_control_ff <= bus_wdata_i[7:0];
				ADDR_TX_HOLDING: tx_holding_ff <= bus_wdata_i[7:0];
				ADDR_PORT_PIN_DATA: port_pin_data_ff <= bus_wdata_i[7:0];
				ADDR_PORT_CONTROL: port_control_ff <= bus_wdata_i;
				default: ;
			endcase
		end
	end

	// Register reads, one cycle latency, unmapped reads zero
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus_rdata_o <= '0;
		end else if (clk_en_i && bus_rd_i) begin
			unique case (bus_addr_i)
				ADDR_FRAME_MODE: bus_rdata_o <= {8'h00, frame_mode_ff};
				ADDR_BIT_RATE: bus_rdata_o <= {8'h00, bit_rate_divisor_ff};
				ADDR_SERIAL_CTRL: bus_rdata_o <= {8'h00, serial_control_ff};
				ADDR_TX_HOLDING: bus_rdata_o <= {8'h00, tx_holding_ff};
				ADDR_SERIAL_STATUS: bus_rdata_o <= {8'h00, tx_empty_flag_ff, rdrf_ff, orer_ff, fer_ff, per_ff,
					tend_ff, mpb_ff, mpbt_ff};
				ADDR_RX_HOLDING: bus_rdata_o <= {8'h00, rx_holding_ff};
				// Pin levels replace stored bits so software sees a break
				ADDR_PORT_PIN_DATA: bus_rdata_o <= {8'h00, port_pin_data_ff[7:6], sck_s2_ff, rx_s2_ff,
					port_pin_data_ff[3:0]};
				ADDR_PORT_CONTROL: bus_rdata_o <= port_control_ff;
				default: bus_rdata_o <= '0;
			endcase
		end
	end

	// Pin multiplexing: serial function only when enabled, else general port
	logic sck_serial;
	assign sck_serial = ~ext_clk & (sync_mode ? (tx_en | rx_en) : serial_control_ff[CR_CLOCK_ENABLE_BIT0]);
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			serial_out_pin_o <= 1'b1;
			serial_out_oe_o <= 1'b0;
			serial_clock_pin_o <= 1'b1;
			serial_clock_oe_o <= 1'b0;
		end else if (clk_en_i) begin
			// Transmit disabled: port bit drives the line when its pin mode is output, a low is a break
			serial_out_pin_o <= tx_en ? tx_out_ff : port_pin_data_ff[PD_SER];
			serial_out_oe_o <= tx_en | (port_control_ff[PC_SER_HI:PC_SER_LO] == PIN_MODE_OUT);
			serial_clock_pin_o <= sck_serial ? sck_int_ff : port_pin_data_ff[PD_SCK];
			serial_clock_oe_o <= sck_serial
				| (~ext_clk & (port_control_ff[PC_SCK_HI:PC_SCK_LO] == PIN_MODE_OUT));
		end
	end

	// Four interrupt requests, each gated by its enable
	assign irq_tx_empty_o = serial_control_ff[CR_TXIE] & tx_empty_flag_ff;
	assign irq_tx_end_o = serial_control_ff[CR_TEIE] & tend_ff;
	assign irq_rx_full_o = serial_control_ff[CR_RXIE] & rdrf_ff;
	assign irq_rx_err_o = serial_control_ff[CR_RXIE] & (orer_ff | fer_ff | per_ff);
endmodule

// >>> dv/sci_assertions.sv
`timescale 1ns/1ps
// Port-level watch on the serial block
module sci_assertions (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [sci_pkg::BUS_W-1:0] bus_rdata_o,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_oe_o,
	input wire logic serial_clock_oe_o,
	input wire logic irq_tx_empty_o,
	input wire logic irq_rx_full_o,
	input wire logic irq_rx_err_o
);
	import sci_pkg::*;
	// One clock domain, one reset
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_reset_idle_line: assert property ($fell(sys_rst_i) |-> serial_out_pin_o && !serial_out_oe_o
		&& !serial_clock_oe_o && !irq_tx_empty_o && !irq_rx_full_o)
		else $error("pins not idle after reset");
	a_stopped_frozen: assert property (!clk_en_i |=> $stable(serial_out_pin_o) && $stable(bus_rdata_o)
		&& $stable(serial_out_oe_o) && $stable(irq_rx_full_o))
		else $error("outputs moved while stopped");
	a_rdata_holds: assert property (!(bus_rd_i && clk_en_i) |=> $stable(bus_rdata_o))
		else $error("read data moved without a read");
	a_txe_clear_write: assert property ($fell(irq_tx_empty_o) |-> $past(bus_wr_i))
		else $error("empty request dropped without a write");
	a_rxf_clear_write: assert property ($fell(irq_rx_full_o) |-> $past(bus_wr_i))
		else $error("full request dropped without a write");
	a_err_clear_write: assert property ($fell(irq_rx_err_o) |-> $past(bus_wr_i))
		else $error("error request dropped without a write");
	a_txoe_by_write: assert property ($changed(serial_out_oe_o)
		|-> $past(bus_wr_i) || $past(bus_wr_i, 2) || $past(bus_wr_i, 3))
		else $error("transmit pin role changed without a write");
	a_clkoe_by_write: assert property ($changed(serial_clock_oe_o)
		|-> $past(bus_wr_i) || $past(bus_wr_i, 2) || $past(bus_wr_i, 3))
		else $error("clock pin role changed without a write");
endmodule

bind sci_top sci_assertions i_sci_assertions (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
	.bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .serial_out_pin_o(serial_out_pin_o),
	.serial_out_oe_o(serial_out_oe_o), .serial_clock_oe_o(serial_clock_oe_o),
	.irq_tx_empty_o(irq_tx_empty_o), .irq_rx_full_o(irq_rx_full_o), .irq_rx_err_o(irq_rx_err_o));

// >>> dv/sci_partner.sv
`timescale 1ns/1ps
// Far-end start-stop partner
module sci_partner #(
	parameter int BIT = 16
) (
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o
);
	logic [8:0] q[$]; // Captured characters, oldest first
	int nb = 8; // Bits kept after the start bit
	// Line idles high
	initial line_o = 1'b1;
	// Start low, bits LSB first, then stop level left standing
	task automatic send(input logic [8:0] d, input int n, input logic stp);
		@(negedge clk_i);
		line_o = 1'b0;
		repeat (BIT) @(negedge clk_i);
		for (int i = 0; i < n; i++) begin
			line_o = d[i];
			repeat (BIT) @(negedge clk_i);
		end
		line_o = stp;
		repeat (BIT) @(negedge clk_i);
	endtask
	// Hold the line at a level, e.g. to end a break
	task automatic set(input logic v);
		@(negedge clk_i);
		line_o = v;
	endtask
	// Capture; short glitches rejected at mid-start
	always begin
		logic [8:0] w;
		@(negedge line_i);
		w = '0;
		repeat (BIT / 2) @(posedge clk_i);
		if (!line_i) begin
			for (int i = 0; i < nb; i++) begin
				repeat (BIT) @(posedge clk_i);
				w[i] = line_i;
			end
			q.push_back(w);
		end
	end
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the serial block
module testbench;
	import sci_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic clk_en_i = 1'b1;
	logic [31:0] bus_addr_i = '0;
	logic bus_wr_i = 1'b0;
	logic bus_rd_i = 1'b0;
	logic [BUS_W-1:0] bus_wdata_i = '0;
	logic [BUS_W-1:0] bus_rdata_o;
	logic serial_in_pin_i, serial_out_pin_o, serial_out_oe_o, serial_clock_pin_o, serial_clock_oe_o;
	logic irq_tx_empty_o, irq_tx_end_o, irq_rx_full_o, irq_rx_err_o;
	logic tx_line; // Pulled up when undriven
	logic [15:0] rv; // Last read value
	int miscompares = 0;
	int samples_checked = 0;
	assign tx_line = serial_out_oe_o ? serial_out_pin_o : 1'b1;
	// 250 MHz clock
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	sci_top i_sci_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .bus_addr_i(bus_addr_i),
		.bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
		.serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o), .serial_out_oe_o(serial_out_oe_o),
		.serial_clock_pin_i(serial_clock_pin_o), .serial_clock_pin_o(serial_clock_pin_o),
		.serial_clock_oe_o(serial_clock_oe_o),
		.irq_tx_empty_o(irq_tx_empty_o), .irq_tx_end_o(irq_tx_end_o), .irq_rx_full_o(irq_rx_full_o),
		.irq_rx_err_o(irq_rx_err_o));
	sci_partner i_sci_partner (.clk_i(clk_i), .line_i(tx_line), .line_o(serial_in_pin_i));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// One-cycle write strobe, launched off the falling edge
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(negedge clk_i);
		bus_addr_i = a;
		bus_wdata_i = d;
		bus_wr_i = 1'b1;
		@(negedge clk_i);
		bus_wr_i = 1'b0;
	endtask
	// Read data is registered, so take it a cycle later
	task automatic rd(input logic [31:0] a, output logic [15:0] d);
		@(negedge clk_i);
		bus_addr_i = a;
		bus_rd_i = 1'b1;
		@(negedge clk_i);
		bus_rd_i = 1'b0;
		d = bus_rdata_o;
	endtask
	// Bounded poll so a stuck flag cannot hang the run
	task automatic wait_st(input int b, input logic v);
		for (int i = 0; i < 600; i++) begin
			rd(ADDR_SERIAL_STATUS, rv);
			if (rv[b] === v) break;
		end
	endtask
	task automatic wait_q(input int n);
		for (int i = 0; i < 2000 && i_sci_partner.q.size() < n; i++)
			@(negedge clk_i);
	endtask
	// Reset map, a hole, a read-only place, a write while stopped
	task automatic t_regs();
		logic [31:0] a[9] = '{ADDR_FRAME_MODE, ADDR_BIT_RATE, ADDR_SERIAL_CTRL, ADDR_TX_HOLDING,
			ADDR_SERIAL_STATUS, ADDR_RX_HOLDING, ADDR_PORT_PIN_DATA, ADDR_PORT_CONTROL, 32'hFFFFFE8C};
		logic [7:0] e[9] = '{RST_FRAME_MODE, RST_BIT_RATE, RST_SERIAL_CTRL, RST_TX_HOLDING,
			RST_SERIAL_STATUS, RST_RX_HOLDING, RST_PORT_PIN_DATA | 8'h10, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++) begin
			rd(a[i], rv);
			chk("reset value", (i == 7) ? RST_PORT_CONTROL : {8'h00, e[i]}, rv);
		end
		wr(ADDR_RX_HOLDING, 16'h00AA);
		@(negedge clk_i);
		clk_en_i = 1'b0;
		wr(ADDR_BIT_RATE, 16'h0012);
		clk_en_i = 1'b1;
		rd(ADDR_RX_HOLDING, rv);
		chk("rx holding", 16'h0000, rv);
		rd(ADDR_BIT_RATE, rv);
		chk("stopped write", {8'h00, RST_BIT_RATE}, rv);
	endtask
	// Port mode drives both pins while the serial side is off
	task automatic t_break();
		wr(ADDR_PORT_PIN_DATA, 16'h0010);
		wr(ADDR_PORT_CONTROL, 16'hA588);
		for (int v = 1; v >= 0; v--) begin
			wr(ADDR_PORT_PIN_DATA, {11'h0, v[0], 4'h0});
			repeat (3) @(negedge clk_i);
			chk("port pins", {13'h0, 2'b11, v[0]},
				{13'h0, serial_clock_oe_o, serial_out_oe_o, serial_out_pin_o});
		end
		wr(ADDR_PORT_CONTROL, RST_PORT_CONTROL);
		wr(ADDR_FRAME_MODE, 16'h0000);
		wr(ADDR_BIT_RATE, 16'h0000);
		wr(ADDR_SERIAL_CTRL, 16'h00F4);
		repeat (200) @(negedge clk_i);
		i_sci_partner.q.delete(); // Break rejected by the partner as a glitch
	endtask
	// Two back to back, then 7-bit with even parity
	task automatic t_tx();
		for (int i = 0; i < 2; i++) begin
			wait_st(ST_TX_EMPTY_FLAG, 1'b1);
			wr(ADDR_TX_HOLDING, {8'h00, 8'hA5 + 8'(i)});
			wr(ADDR_SERIAL_STATUS, 16'h007F);
		end
		wait_q(2);
		for (int i = 0; i < 2; i++)
			chk("tx char", {8'h00, 8'hA5 + 8'(i)}, {7'h0, i_sci_partner.q.pop_front()});
		wait_st(ST_TEND, 1'b1);
		chk("tx irqs", 16'h0003, {14'h0, irq_tx_empty_o, irq_tx_end_o});
		wr(ADDR_FRAME_MODE, 16'h0060);
		wr(ADDR_TX_HOLDING, 16'h0083);
		wr(ADDR_SERIAL_STATUS, 16'h007F);
		wait_q(1);
		chk("7-bit char", 16'h0003, {7'h0, i_sci_partner.q.pop_front()});
	endtask
	// One frame, parity wrong for even, right for odd
	task automatic t_rx_par();
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_FRAME_MODE, i ? 16'h0030 : 16'h0020);
			i_sci_partner.send(9'h001, 9, 1'b1);
			wait_st(ST_RDRF, 1'b1);
			chk("rx full irq", 16'h0001, {15'h0, irq_rx_full_o});
			chk("parity error", {15'h0, i == 0}, {15'h0, rv[ST_PER]});
			chk("error irq", {15'h0, i == 0}, {15'h0, irq_rx_err_o});
			rd(ADDR_RX_HOLDING, rv);
			chk("rx char", 16'h0001, rv);
			wr(ADDR_SERIAL_STATUS, 16'h00B7);
		end
		wr(ADDR_FRAME_MODE, 16'h0000);
	endtask
	// Fill holding and buffer, one more overruns, drain in order
	task automatic t_overrun();
		for (int i = 0; i < 18; i++) begin
			if (i == 17) begin
				rd(ADDR_SERIAL_STATUS, rv);
				chk("early overrun", 16'h0000, {15'h0, rv[ST_ORER]});
			end
			i_sci_partner.send({1'b0, 8'h40 + 8'(i)}, 8, 1'b1);
		end
		wait_st(ST_ORER, 1'b1);
		chk("overrun", 16'h0001, {15'h0, rv[ST_ORER]});
		for (int i = 0; i < 17; i++) begin
			wait_st(ST_RDRF, 1'b1);
			rd(ADDR_RX_HOLDING, rv);
			chk("drained char", {8'h00, 8'h40 + 8'(i)}, rv);
			wr(ADDR_SERIAL_STATUS, 16'h009F);
		end
		repeat (8) @(negedge clk_i);
		rd(ADDR_SERIAL_STATUS, rv);
		chk("buffer empty", 16'h0000, {15'h0, rv[ST_RDRF]});
	endtask
	// Stop bit held low, then the line level read back
	task automatic t_brk_rx();
		i_sci_partner.send(9'h055, 8, 1'b0);
		wait_st(ST_FER, 1'b1);
		chk("framing error", 16'h0001, {15'h0, rv[ST_FER]});
		rd(ADDR_PORT_PIN_DATA, rv);
		chk("rx level", 16'h0000, {15'h0, rv[PD_SER]});
		i_sci_partner.set(1'b1);
		repeat (4) @(negedge clk_i);
		rd(ADDR_PORT_PIN_DATA, rv);
		chk("rx level", 16'h0001, {15'h0, rv[PD_SER]});
	endtask
	// Sync transmit, receiver off: bits taken on clock pin rises
	task automatic t_sync();
		logic [7:0] w;
		wr(ADDR_SERIAL_CTRL, 16'h00A4);
		wr(ADDR_FRAME_MODE, 16'h0080);
		wr(ADDR_TX_HOLDING, 16'h00C9);
		wr(ADDR_SERIAL_STATUS, 16'h007F);
		for (int i = 0; i < 8; i++) begin
			@(posedge serial_clock_pin_o);
			w[i] = serial_out_pin_o;
		end
		chk("sync char", 16'h00C9, {8'h00, w});
	endtask
	task automatic finish_test();
		$display("checked %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk_i);
		sys_rst_i = 1'b0;
		t_regs();
		t_break();
		t_tx();
		t_rx_par();
		t_overrun();
		t_brk_rx();
		t_sync();
		finish_test();
	end
	// Watchdog, several times the expected run
	initial begin
		repeat (40000) @(posedge clk_i);
		miscompares++;
		finish_test();
	end
endmodule
